//--- rtl/sfb_flash_front.sv
// Serial flash front end: serial link, command decode, array
`timescale 1ns/1ps
// Behaviour
// - Output bits change only after a falling serial clock edge.
// - Input bits are sampled on each rising serial clock edge.
// - Input stream is opcode, then address bytes, then data bytes.
// - Chip select high deselects and floats the data output.
// - Standby only when deselected and no internal cycle is running.
// - Chip select low selects the device into active power.
// - After reset, decoding waits for a chip select falling edge.
// - Hold pauses the transfer without deselecting, keeping its state.
// - During hold, output floats; clock and data input are ignored.
// - Hold only takes effect while the device is selected.
// - Write protect pin low freezes the block protect bits while wr_lock is set.
// - Array is 32 sectors of 256 pages of 256 bytes.
// - Page program takes 1 to 256 data bytes.
// - Erase either the whole array or one sector.
// - Clock idles low or high; sampling stays on rising edges.
module sfb_flash_front #(
  parameter int SECT_ERASE_CYC = sfb_pkg::SECT_ERASE_CYC,
  parameter int BULK_ERASE_CYC = sfb_pkg::BULK_ERASE_CYC
) (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic spi_clk_in,
  input  wire logic cs_n_in,
  input  wire logic mosi_in,
  input  wire logic hold_n_in,
  input  wire logic wp_n_in,
  output logic      miso_out,
  output logic      miso_oe_out,
  output logic      standby_out,
  output logic      wip_out
);

  // Link domain state
  logic       link_rst_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_in_r;
  logic [7:0] rx_byte_r;
  logic       rx_tog_r;
  logic       frag_r;
  logic       first_r;
  logic       rd_stat_r;
  logic [7:0] stat_s1_r;
  logic [7:0] stat_s2_r;
  logic [6:0] out_sh_r;
  logic       miso_r;
  logic       miso_oe_r;
  logic [7:0] rx_next;

  // System domain state
  logic [3:0]              sy1_r;
  logic [3:0]              sy2_r;
  logic [3:0]              sy3_r;
  logic [3:0]              stab_r;
  logic [3:0]              stab_nxt;
  logic                    cs_rise;
  logic                    cs_fall;
  logic                    byte_ev;
  sfb_pkg::sfb_frame_t     fr_r;
  sfb_pkg::sfb_exec_t      ex_r;
  logic [7:0]              op_r;
  logic [23:0]             addr_r;
  logic [1:0]              adr_cnt_r;
  logic [8:0]              data_cnt_r;
  logic [7:0]              wr_ix_r;
  logic [7:0]              col_r;
  logic [7:0]              wsr_r;
  sfb_pkg::sfb_status_t    stat_r;
  logic [7:0]              stat_byte_r;
  logic [sfb_pkg::CNT_W-1:0]  idx_r;
  logic [sfb_pkg::CNT_W-1:0]  end_r;
  logic [sfb_pkg::ADDR_W-1:0] base_r;
  logic                    frame_done;
  logic                    standby_r;
  logic                    wip_r;
  logic [2:0]              bp_now;
  logic [sfb_pkg::ADDR_W-1:0] prog_adr;
  logic [7:0]              prog_col;

  logic [7:0] mem  [0:sfb_pkg::MEM_BYTES-1];
  logic [7:0] pbuf [0:sfb_pkg::PAGE_BYTES-1];

  // Upper sectors locked by the block protect code
  function automatic logic prot_hit(input logic [2:0] bp, input logic [4:0] sect);
    logic [5:0] lim;
    lim = 6'h00;
    if (bp == 3'h0) begin
      prot_hit = 1'b0;
    end else if (bp >= 3'h6) begin
      prot_hit = 1'b1;
    end else begin
      lim = 6'h20 - (6'h01 << (bp - 3'h1));
      prot_hit = {1'b0, sect} >= lim;
    end
  endfunction

  // ---------------- Link clock domain ----------------

  assign rx_next = {sh_in_r[6:0], mosi_in};

  // Bit counter and opcode check, cleared by chip select
  always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_r <= 3'h0;
      first_r   <= 1'b1;
      rd_stat_r <= 1'b0;
    end else if (hold_n_in) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        first_r <= 1'b0;
        if (first_r) begin
          rd_stat_r <= (rx_next == sfb_pkg::OP_STAT_RD);
        end
      end
    end
  end

  // Input shifter, data held across hold
  always_ff @(posedge spi_clk_in) begin
    if (!cs_n_in && hold_n_in) begin
      sh_in_r <= rx_next;
      if (bit_cnt_r == 3'h7) begin
        rx_byte_r <= rx_next;
      end
    end
  end

  // Byte toggle and fragment flag toward system domain
  always_ff @(posedge spi_clk_in or posedge link_rst_r) begin
    if (link_rst_r) begin
      rx_tog_r <= 1'b0;
      frag_r   <= 1'b0;
    end else if (!cs_n_in && hold_n_in) begin
      frag_r <= (bit_cnt_r != 3'h7);
      if (bit_cnt_r == 3'h7) begin
        rx_tog_r <= ~rx_tog_r;
      end
    end
  end

  // Status byte brought onto the link clock
  always_ff @(posedge spi_clk_in) begin
    stat_s1_r <= stat_byte_r;
    stat_s2_r <= stat_s1_r;
  end

  // Output shifter on falling edges
  always_ff @(negedge spi_clk_in or posedge link_rst_r) begin
    if (link_rst_r) begin
      miso_r   <= 1'b0;
      out_sh_r <= 7'h00;
    end else if (!cs_n_in && hold_n_in) begin
      if (rd_stat_r && bit_cnt_r == 3'h0) begin
        {miso_r, out_sh_r} <= stat_s2_r;
      end else begin
        {miso_r, out_sh_r} <= {out_sh_r, 1'b0};
      end
    end
  end

  // Output enable: floats at once on deselect or hold
  always_ff @(negedge spi_clk_in or posedge cs_n_in or negedge hold_n_in
              or posedge link_rst_r) begin
    if (cs_n_in || link_rst_r) begin
      miso_oe_r <= 1'b0;
    end else if (!hold_n_in) begin
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= 1'b1;
    end
  end

  assign miso_out    = miso_r;
  assign miso_oe_out = miso_oe_r;

  // ---------------- System clock domain ----------------

  // Reset forwarded to the link side
  always_ff @(posedge mclk_in) begin
    link_rst_r <= srst_in;
  end

  // Three-stage synchronisers, change taken when stages agree
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sy1_r  <= sfb_pkg::SY_RST;
      sy2_r  <= sfb_pkg::SY_RST;
      sy3_r  <= sfb_pkg::SY_RST;
      stab_r <= sfb_pkg::SY_RST;
    end else begin
      sy1_r  <= {wp_n_in, frag_r, rx_tog_r, cs_n_in};
      sy2_r  <= sy1_r;
      sy3_r  <= sy2_r;
      stab_r <= stab_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      stab_nxt[i] = (sy2_r[i] == sy3_r[i]) ? sy3_r[i] : stab_r[i];
    end
  end

  // Events; chip select reads low after reset so a rise must come first
  assign cs_rise = stab_nxt[sfb_pkg::SY_CS] & ~stab_r[sfb_pkg::SY_CS];
  assign cs_fall = ~stab_nxt[sfb_pkg::SY_CS] & stab_r[sfb_pkg::SY_CS];
  assign byte_ev = stab_nxt[sfb_pkg::SY_TOG] ^ stab_r[sfb_pkg::SY_TOG];
  assign frame_done = cs_rise && !stab_nxt[sfb_pkg::SY_FRAG] &&
                      (fr_r == sfb_pkg::FR_DATA);

  // Frame decoder: opcode, address, data
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fr_r       <= sfb_pkg::FR_WAIT;
      op_r       <= 8'h00;
      addr_r     <= 24'h00_0000;
      adr_cnt_r  <= 2'h0;
      data_cnt_r <= 9'h000;
      wr_ix_r    <= 8'h00;
      col_r      <= 8'h00;
      wsr_r      <= 8'h00;
    end else if (cs_fall) begin
      fr_r       <= sfb_pkg::FR_OP;
      adr_cnt_r  <= 2'h0;
      data_cnt_r <= 9'h000;
    end else if (cs_rise) begin
      fr_r <= sfb_pkg::FR_WAIT;
    end else if (byte_ev) begin
      case (fr_r)
        sfb_pkg::FR_OP: begin
          op_r <= rx_byte_r;
          if (rx_byte_r == sfb_pkg::OP_PAGE_PROG ||
              rx_byte_r == sfb_pkg::OP_SECT_ERASE) begin
            fr_r <= sfb_pkg::FR_ADDR;
          end else begin
            fr_r <= sfb_pkg::FR_DATA;
          end
        end
        sfb_pkg::FR_ADDR: begin
          addr_r    <= {addr_r[15:0], rx_byte_r};
          adr_cnt_r <= adr_cnt_r + 2'h1;
          if (adr_cnt_r == 2'h2) begin
            fr_r    <= sfb_pkg::FR_DATA;
            wr_ix_r <= rx_byte_r;
            col_r   <= rx_byte_r;
          end
        end
        sfb_pkg::FR_DATA: begin
          wr_ix_r <= wr_ix_r + 8'h01;
          if (data_cnt_r == 9'h000) begin
            wsr_r <= rx_byte_r;
          end
          if (data_cnt_r != 9'h100) begin
            data_cnt_r <= data_cnt_r + 9'h001;
          end
        end
        default: begin
          fr_r <= sfb_pkg::FR_WAIT;
        end
      endcase
    end
  end

  // Page buffer, wraps within the page
  always_ff @(posedge mclk_in) begin
    if (byte_ev && fr_r == sfb_pkg::FR_DATA) begin
      pbuf[wr_ix_r] <= rx_byte_r;
    end
  end

  assign bp_now = {stat_r.block_protect_bit2, stat_r.block_protect_bit1,
                   stat_r.block_protect_bit0};

  // Status bits and internal program/erase cycles
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      stat_r <= sfb_pkg::STATUS_RST;
      ex_r   <= sfb_pkg::EX_IDLE;
      idx_r  <= '0;
      end_r  <= '0;
      base_r <= '0;
    end else begin
      stat_r.zero <= 2'h0;
      if (ex_r != sfb_pkg::EX_IDLE) begin
        idx_r <= idx_r + 22'h00_0001;
        if (idx_r + 22'h00_0001 == end_r) begin
          ex_r <= sfb_pkg::EX_IDLE;
        end
      end else if (frame_done) begin
        case (op_r)
          sfb_pkg::OP_WR_ENABLE:  stat_r.wr_en <= 1'b1;
          sfb_pkg::OP_WR_DISABLE: stat_r.wr_en <= 1'b0;
          sfb_pkg::OP_STAT_WR: begin
            if (stat_r.wr_en && data_cnt_r != 9'h000) begin
              stat_r.wr_en <= 1'b0;
              if (!(stat_r.wr_lock && !stab_r[sfb_pkg::SY_WP])) begin
                stat_r.wr_lock            <= wsr_r[7];
                stat_r.block_protect_bit2 <= wsr_r[4];
                stat_r.block_protect_bit1 <= wsr_r[3];
                stat_r.block_protect_bit0 <= wsr_r[2];
              end
            end
          end
          sfb_pkg::OP_PAGE_PROG: begin
            if (stat_r.wr_en && data_cnt_r != 9'h000) begin
              stat_r.wr_en <= 1'b0;
              if (!prot_hit(bp_now, addr_r[20:16])) begin
                ex_r   <= sfb_pkg::EX_PROG;
                idx_r  <= '0;
                end_r  <= {13'h0000, data_cnt_r};
                base_r <= addr_r[20:0];
              end
            end
          end
          sfb_pkg::OP_SECT_ERASE: begin
            if (stat_r.wr_en) begin
              stat_r.wr_en <= 1'b0;
              if (!prot_hit(bp_now, addr_r[20:16])) begin
                ex_r   <= sfb_pkg::EX_ERASE;
                idx_r  <= '0;
                end_r  <= 22'(SECT_ERASE_CYC);
                base_r <= {addr_r[20:16], 16'h0000};
              end
            end
          end
          sfb_pkg::OP_BULK_ERASE: begin
            if (stat_r.wr_en) begin
              stat_r.wr_en <= 1'b0;
              if (bp_now == 3'h0) begin
                ex_r   <= sfb_pkg::EX_ERASE;
                idx_r  <= '0;
                end_r  <= 22'(BULK_ERASE_CYC);
                base_r <= '0;
              end
            end
          end
          default: begin
            ex_r <= sfb_pkg::EX_IDLE;
          end
        endcase
      end
    end
  end

  assign prog_col = col_r + idx_r[7:0];
  assign prog_adr = {base_r[20:8], prog_col};

  // Array writes: program clears bits, erase sets bytes
  always_ff @(posedge mclk_in) begin
    if (ex_r == sfb_pkg::EX_PROG) begin
      mem[prog_adr] <= mem[prog_adr] & pbuf[prog_col];
    end else if (ex_r == sfb_pkg::EX_ERASE) begin
      mem[base_r + idx_r[20:0]] <= sfb_pkg::ERASED_BYTE;
    end
  end

  // Status byte, power mode and busy outputs
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      stat_byte_r <= sfb_pkg::STATUS_RST;
      standby_r   <= 1'b0;
      wip_r       <= 1'b0;
    end else begin
      stat_byte_r <= {stat_r[7:1], ex_r != sfb_pkg::EX_IDLE};
      standby_r   <= stab_nxt[sfb_pkg::SY_CS] && ex_r == sfb_pkg::EX_IDLE;
      wip_r       <= ex_r != sfb_pkg::EX_IDLE;
    end
  end

  assign standby_out = standby_r;
  assign wip_out     = wip_r;

endmodule

//--- inc/sfb_pkg.sv
// Constants and types of the serial flash bus front end
package sfb_pkg;
  // Array organisation
  localparam int SECT_CNT      = 32;
  localparam int PAGES_PER_SEC = 256;
  localparam int PAGE_BYTES    = 256;
  localparam int MEM_BYTES     = SECT_CNT * PAGES_PER_SEC * PAGE_BYTES;
  localparam int ADDR_W        = 21;
  localparam int CNT_W         = 22;
  localparam int SECT_LSB      = 16;
  // Instruction codes
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STAT_RD    = 8'h05;
  localparam logic [7:0] OP_STAT_WR    = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  // Timing of the internal cycles, in clock cycles
  localparam int SECT_ERASE_CYC = 65536;
  localparam int BULK_ERASE_CYC = 2097152;
  // Synchroniser lanes
  localparam int SY_CS   = 0;
  localparam int SY_TOG  = 1;
  localparam int SY_FRAG = 2;
  localparam int SY_WP   = 3;
  localparam logic [3:0] SY_RST = 4'h0;
  // Status byte layout
  typedef struct packed {
    logic       wr_lock;
    logic [1:0] zero;
    logic       block_protect_bit2;
    logic       block_protect_bit1;
    logic       block_protect_bit0;
    logic       wr_en;
    logic       busy;
  } sfb_status_t;
  localparam logic [7:0] STATUS_RST = 8'h00;
  typedef enum {FR_WAIT, FR_OP, FR_ADDR, FR_DATA} sfb_frame_t;
  typedef enum {EX_IDLE, EX_PROG, EX_ERASE} sfb_exec_t;
endpackage

//--- testbench/sfb_flash_front_monitor.sv
// Port checker of the serial flash front end
`timescale 1ns/1ps
module sfb_flash_front_chk #(
  parameter int SECT_ERASE_CYC = 64,
  parameter int BULK_ERASE_CYC = 64
) (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic cs_n_in,
  input  wire logic hold_n_in,
  input  wire logic miso_oe_out,
  input  wire logic standby_out,
  input  wire logic wip_out
);
  localparam int WIP_MAX = 300;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // Deselected with no internal cycle
  sequence idle_run;
    (cs_n_in && !wip_out) [*8];
  endsequence
  // Selected long enough to pass the synchroniser
  sequence sel_run;
    !cs_n_in [*6];
  endsequence
  // Output enable, power mode and internal cycle relations
  desel_float_a: assert property (cs_n_in |-> !miso_oe_out)
    else $error("output driven while deselected");
  hold_float_a: assert property (!hold_n_in |-> !miso_oe_out)
    else $error("output driven during hold");
  oe_start_a: assert property ($rose(miso_oe_out) |-> !cs_n_in && hold_n_in)
    else $error("output enabled outside selection");
  standby_enter_a: assert property (idle_run |-> standby_out)
    else $error("no standby while idle");
  standby_busy_a: assert property (wip_out |-> !standby_out)
    else $error("standby during internal cycle");
  active_sel_a: assert property (sel_run |-> !standby_out)
    else $error("standby while selected");
  wip_start_a: assert property ($rose(wip_out) |-> cs_n_in)
    else $error("internal cycle started while selected");
  wip_end_a: assert property ($rose(wip_out) |-> ##[1:WIP_MAX] !wip_out)
    else $error("internal cycle too long");
endmodule

//--- testbench/sfb_spi_master.sv
// SPI bus master model for the serial flash front end
`timescale 1ns/1ps
module sfb_spi_master (
  input  wire logic mclk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_in,
  output logic      spi_clk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  output logic      hold_n_out
);
  logic q_last = 1'b0;
  logic cpol   = 1'b0;
  logic q_line;
  // Released data line shows the inverse of its last level
  always @(miso_in or miso_oe_in) if (miso_oe_in) q_last = miso_in;
  assign q_line = miso_oe_in ? miso_in : ~q_last;
  // Idle bus at time zero
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    hold_n_out = 1'b1;
  end
  // Park clock at idle level, then a chip select fall
  task automatic sel(input logic pol);
    repeat (6) @(negedge mclk_in);
    cpol = pol;
    spi_clk_out = pol;
    @(negedge mclk_in);
    cs_n_out = 1'b0;
    #53.3;
  endtask
  // Top n bits MSB first, read back on rising edges
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 7; i > 7 - n; i--) begin
      spi_clk_out = 1'b0;
      mosi_out = tx[i];
      #7.5;
      spi_clk_out = 1'b1;
      rx = {rx[6:0], q_line};
      #7.5;
    end
    spi_clk_out = cpol;
    mosi_out = ~mosi_out;
  endtask
  // Quiet clock, then deselect
  task automatic desel();
    #45;
    @(negedge mclk_in);
    cs_n_out = 1'b1;
  endtask
  // Hold level, used only while selected
  task automatic hold(input logic v);
    @(negedge mclk_in);
    hold_n_out = v;
  endtask
endmodule

//--- testbench/serial_flash_bus_front_end_tb.sv
// Self-checking bench of the serial flash front end
`timescale 1ns/1ps
module serial_flash_bus_front_end_tb;
  localparam int SE_CYC = 32;
  localparam int BE_CYC = 64;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       wp_n = 1'b1;
  logic       spi_clk, cs_n, mosi, hold_n, miso, miso_oe, standby, wip;
  logic [7:0] rx;
  int         n;
  int         err_total = 0;
  int         num_checks = 0;
  always #5 mclk = ~mclk;
  sfb_flash_front #(.SECT_ERASE_CYC(SE_CYC), .BULK_ERASE_CYC(BE_CYC)) DUT (
    .mclk_in(mclk), .srst_in(srst), .spi_clk_in(spi_clk), .cs_n_in(cs_n),
    .mosi_in(mosi), .hold_n_in(hold_n), .wp_n_in(wp_n), .miso_out(miso),
    .miso_oe_out(miso_oe), .standby_out(standby), .wip_out(wip));
  sfb_spi_master mst (
    .mclk_in(mclk), .miso_in(miso), .miso_oe_in(miso_oe), .spi_clk_out(spi_clk),
    .cs_n_out(cs_n), .mosi_out(mosi), .hold_n_out(hold_n));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Frames
  task automatic cmd(input logic [7:0] op);
    mst.sel(1'b0);
    mst.bits(op, 8, rx);
    mst.desel();
  endtask
  task automatic wrsr(input logic [7:0] v);
    mst.sel(1'b0);
    mst.bits(sfb_pkg::OP_STAT_WR, 8, rx);
    mst.bits(v, 8, rx);
    mst.desel();
  endtask
  task automatic addr_cmd(input logic [7:0] op, input logic [23:0] a, input int nb);
    int i;
    mst.sel(1'b0);
    mst.bits(op, 8, rx);
    for (i = 2; i >= 0; i--) mst.bits(a[i*8 +: 8], 8, rx);
    for (i = 0; i < nb; i++) mst.bits(8'(i), 8, rx);
    mst.desel();
  endtask
  task automatic rd_stat(input logic pol, input logic [7:0] exp);
    mst.sel(pol);
    mst.bits(sfb_pkg::OP_STAT_RD, 8, rx);
    mst.bits(8'h00, 8, rx);
    chk(16'(miso_oe), 16'h0001);
    chk(16'(rx), 16'(exp));
    mst.desel();
    #20;
    chk(16'(miso_oe), 16'h0000);
  endtask
  // Length of the next internal cycle in clock cycles
  task automatic wip_len(output int c);
    int k;
    c = 0;
    for (k = 0; k < 400 && wip !== 1'b1; k++) @(negedge mclk);
    while (wip === 1'b1 && c < 400) begin
      c++;
      @(negedge mclk);
    end
  endtask
  // Scenarios
  task automatic t_modes();
    rd_stat(1'b0, sfb_pkg::STATUS_RST);
    rd_stat(1'b1, sfb_pkg::STATUS_RST);
    cmd(sfb_pkg::OP_WR_ENABLE);
    rd_stat(1'b1, 8'h02);
    cmd(sfb_pkg::OP_WR_DISABLE);
    rd_stat(1'b0, 8'h00);
    $display("modes done");
  endtask
  task automatic t_abort();
    mst.sel(1'b0);
    mst.bits(sfb_pkg::OP_WR_ENABLE, 7, rx);
    mst.desel();
    rd_stat(1'b0, 8'h00);
    $display("abort done");
  endtask
  task automatic t_hold();
    cmd(sfb_pkg::OP_WR_ENABLE);
    mst.sel(1'b0);
    mst.bits(sfb_pkg::OP_STAT_RD, 4, rx);
    mst.hold(1'b0);
    mst.bits(8'hff, 8, rx);
    chk(16'(miso_oe), 16'h0000);
    mst.hold(1'b1);
    mst.bits(8'h50, 4, rx);
    mst.bits(8'h00, 8, rx);
    chk(16'(rx), 16'h0002);
    mst.desel();
    $display("hold done");
  endtask
  task automatic t_prog();
    int k;
    for (k = 1; k <= 256; k += 255) begin
      cmd(sfb_pkg::OP_WR_ENABLE);
      addr_cmd(sfb_pkg::OP_PAGE_PROG, 24'h00_0100, k);
      wip_len(n);
      chk(16'(n), 16'(k));
    end
    $display("program done");
  endtask
  task automatic t_erase();
    cmd(sfb_pkg::OP_WR_ENABLE);
    addr_cmd(sfb_pkg::OP_SECT_ERASE, 24'h1f_0000, 0);
    wip_len(n);
    chk(16'(n), 16'(SE_CYC));
    cmd(sfb_pkg::OP_WR_ENABLE);
    cmd(sfb_pkg::OP_BULK_ERASE);
    wip_len(n);
    chk(16'(n), 16'(BE_CYC));
    $display("erase done");
  endtask
  task automatic t_wp();
    cmd(sfb_pkg::OP_WR_ENABLE);
    wrsr(8'h9c);
    rd_stat(1'b0, 8'h9c);
    @(negedge mclk);
    wp_n = 1'b0;
    cmd(sfb_pkg::OP_WR_ENABLE);
    wrsr(8'h00);
    rd_stat(1'b0, 8'h9c);
    cmd(sfb_pkg::OP_WR_ENABLE);
    addr_cmd(sfb_pkg::OP_SECT_ERASE, 24'h00_0000, 0);
    wip_len(n);
    chk(16'(n), 16'h0000);
    @(negedge mclk);
    wp_n = 1'b1;
    cmd(sfb_pkg::OP_WR_ENABLE);
    wrsr(8'h00);
    rd_stat(1'b0, 8'h00);
    $display("protect done");
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    t_modes();
    t_abort();
    t_hold();
    t_prog();
    t_erase();
    t_wp();
    stop_test();
  end
  // Watchdog
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
endmodule
bind sfb_flash_front sfb_flash_front_chk chk_i (
  .mclk_in(mclk_in), .srst_in(srst_in), .cs_n_in(cs_n_in), .hold_n_in(hold_n_in),
  .miso_oe_out(miso_oe_out), .standby_out(standby_out), .wip_out(wip_out));
